/* File: include/fsrb_regs.svh */
// Operation
// - Decode offsets 0-7, 6 reserved.
// - Status A visible except in baseline.
// - Status B visible except in baseline.
// - Enhanced status A bit layout.
// - Direction and side bits active high.
// - Protect, index, track zero active low.
// - Second drive bit always reads one.
// - Alternate status A bit layout.
// - Alternate direction, side inverted; inputs high.
// - Step latch cleared by input read, resets.
// - Bit 7 shows interrupt output.
// - Status B bit layout, reset c0.
// - Motor bits: hardware reset only.
// - Bit 2 shows write gate.
// - Data toggles flip on inactive edges.
// - Bit 5 mirrors drive select 0.
`ifndef FSRB_REGS_SVH
`define FSRB_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FSRB_OFS_STATUS_A   3'h0
`define FSRB_OFS_STATUS_B   3'h1
`define FSRB_OFS_DRIVE_CTL  3'h2
`define FSRB_OFS_TAPE       3'h3
`define FSRB_OFS_MAIN_STAT  3'h4
`define FSRB_OFS_FIFO       3'h5
`define FSRB_OFS_RESERVED   3'h6
`define FSRB_OFS_INPUT_STAT 3'h7

// ----------------------------------------
// Drive output control fields
// ----------------------------------------
`define FSRB_DOC_SEL0       0
`define FSRB_DOC_SEL1       1
`define FSRB_DOC_RESET_N    2
`define FSRB_DOC_DMA_EN     3
`define FSRB_DOC_MOTOR0     4
`define FSRB_DOC_MOTOR1     5

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define FSRB_DOC_RESET      8'h00
`define FSRB_TAPE_RESET     2'h0
`define FSRB_STATUS_B_RESET 8'hc0
`define FSRB_ONES2          2'h3
`define FSRB_ZEROS6         6'h00

`endif

/* File: include/fsrb_pkg.sv */
// ----------------------------------------
// Types shared by the status bank
// ----------------------------------------
package fsrb_pkg;

  // Compatibility mode, one code is illegal
  typedef enum logic [1:0] {
    fsrb_mode_enhanced,
    fsrb_mode_alternate,
    fsrb_mode_baseline
  } fsrb_mode_type;

  // Drive pins and core state seen by the bank
  typedef struct packed {
    logic write_protect_n;
    logic index_pulse_n;
    logic track_zero_n;
    logic head_side_select;
    logic step;
    logic direction;
    logic read_data;
    logic write_data;
    logic write_gate;
    logic irq;
    logic dma_request_pending;
  } fsrb_drive_in_type;

  // Controls taken from drive output control
  typedef struct packed {
    logic       motor_out_1;
    logic       motor_out_0;
    logic [1:0] drive_sel;
    logic       dma_enable;
    logic       soft_reset;
  } fsrb_drive_out_type;

  // Strobes towards the command core
  typedef struct packed {
    logic rate_wr;
    logic fifo_wr;
    logic fifo_rd;
    logic config_wr;
    logic input_rd;
  } fsrb_strobe_type;

endpackage : fsrb_pkg

/* File: rtl/fsrb_bank.sv */
`timescale 1ns/10ps
`include "fsrb_regs.svh"

module fsrb_bank (
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Byte I/O cycle from the host side
  input  wire logic [2:0]                  io_addr,
  input  wire logic                        io_rd,
  input  wire logic                        io_wr,
  input  wire logic [7:0]                  io_wdata,
  output logic      [7:0]                  io_rdata,
  output logic                             io_rdata_oe,
  // Configuration
  input  wire fsrb_pkg::fsrb_mode_type     compat_mode,
  // Drive pins and core state
  input  wire fsrb_pkg::fsrb_drive_in_type drive_in,
  // Read values of registers kept by the core
  input  wire logic [7:0]                  core_main_stat,
  input  wire logic [7:0]                  core_fifo,
  input  wire logic [7:0]                  core_input_stat,
  // Towards drive and core
  output fsrb_pkg::fsrb_drive_out_type     drive_out,
  output fsrb_pkg::fsrb_strobe_type        core_strobe,
  output logic      [7:0]                  core_wdata
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // One select line per offset except 6
  wire logic sel_a;
  wire logic sel_b;
  wire logic sel_doc;
  wire logic sel_tape;
  wire logic sel_main;
  wire logic sel_fifo;
  wire logic sel_input;

  assign sel_a     = (io_addr == `FSRB_OFS_STATUS_A);
  assign sel_b     = (io_addr == `FSRB_OFS_STATUS_B);
  assign sel_doc   = (io_addr == `FSRB_OFS_DRIVE_CTL);
  assign sel_tape  = (io_addr == `FSRB_OFS_TAPE);
  assign sel_main  = (io_addr == `FSRB_OFS_MAIN_STAT);
  assign sel_fifo  = (io_addr == `FSRB_OFS_FIFO);
  assign sel_input = (io_addr == `FSRB_OFS_INPUT_STAT);

  // Offset 6 matches no select, so it is
  // never driven and writes are dropped

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------

  // Mode flags
  logic mode_enh;
  logic mode_alt;
  logic mode_base;

  // Illegal code falls back to baseline,
  // the safest view since it hides A and B
  always_comb begin
    mode_enh  = 1'b0;
    mode_alt  = 1'b0;
    mode_base = 1'b0;
    unique case (compat_mode)
      fsrb_pkg::fsrb_mode_enhanced: begin
        mode_enh = 1'b1;
      end
      fsrb_pkg::fsrb_mode_alternate: begin
        mode_alt = 1'b1;
      end
      fsrb_pkg::fsrb_mode_baseline: begin
        mode_base = 1'b1;
      end
      default: begin
        mode_base = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Drive output control register
  // ----------------------------------------

  // Drive output control contents
  logic [7:0] doc;
  // Tape assignment, two bits only
  logic [1:0] tape_sel;

  // Write strobes
  wire logic wr_doc;
  wire logic wr_tape;

  assign wr_doc  = io_wr & sel_doc;
  assign wr_tape = io_wr & sel_tape;

  // Hardware reset only; the soft reset bit
  // lives here and must not clear itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doc <= `FSRB_DOC_RESET;
    end else if (wr_doc) begin
      doc <= io_wdata;
    end
  end

  // Tape register ignores soft reset too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tape_sel <= `FSRB_TAPE_RESET;
    end else if (wr_tape) begin
      tape_sel <= io_wdata[1:0];
    end
  end

  // Soft reset while the bit reads zero
  wire logic soft_rst;

  assign soft_rst = ~doc[`FSRB_DOC_RESET_N];

  // Motor outputs follow the stored bits
  // One driver for the whole struct keeps lint quiet
  assign drive_out = '{
    motor_out_1: doc[`FSRB_DOC_MOTOR1],
    motor_out_0: doc[`FSRB_DOC_MOTOR0],
    drive_sel:   doc[`FSRB_DOC_SEL1:`FSRB_DOC_SEL0],
    dma_enable:  doc[`FSRB_DOC_DMA_EN],
    soft_reset:  soft_rst
  };

  // ----------------------------------------
  // Edge detection on drive signals
  // ----------------------------------------

  // Previous samples
  logic step_q;
  logic rdata_q;
  logic wdata_q;

  // Inputs are synchronous, one stage is enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q  <= 1'b0;
      rdata_q <= 1'b0;
      wdata_q <= 1'b0;
    end else begin
      step_q  <= drive_in.step;
      rdata_q <= drive_in.read_data;
      wdata_q <= drive_in.write_data;
    end
  end

  // Step going active
  wire logic step_rise;
  // Data pulses going inactive
  wire logic rdata_fall;
  wire logic wdata_fall;

  assign step_rise  = drive_in.step & ~step_q;
  assign rdata_fall = rdata_q & ~drive_in.read_data;
  assign wdata_fall = wdata_q & ~drive_in.write_data;

  // ----------------------------------------
  // Step latch
  // ----------------------------------------

  // Latched step flag
  logic step_latch;

  // Read of the input status clears it
  wire logic rd_input;

  assign rd_input = io_rd & sel_input;

  // A new step beats a clear in the same cycle,
  // otherwise a step edge could be lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_latch <= 1'b0;
    end else if (step_rise) begin
      step_latch <= 1'b1;
    end else if (rd_input | soft_rst) begin
      step_latch <= 1'b0;
    end
  end

  // ----------------------------------------
  // Data toggles
  // ----------------------------------------

  // Toggle flip-flops
  logic rdata_tog;
  logic wdata_tog;

  // Only a hardware reset clears them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_tog <= 1'b0;
      wdata_tog <= 1'b0;
    end else begin
      rdata_tog <= rdata_tog ^ rdata_fall;
      wdata_tog <= wdata_tog ^ wdata_fall;
    end
  end

  // ----------------------------------------
  // Status A layouts
  // ----------------------------------------

  // Enhanced view
  wire logic [7:0] status_a_enh;
  // Alternate view
  wire logic [7:0] status_a_alt;

  assign status_a_enh = {
    drive_in.irq,
    1'b1,
    drive_in.step,
    drive_in.track_zero_n,
    drive_in.head_side_select,
    drive_in.index_pulse_n,
    drive_in.write_protect_n,
    drive_in.direction
  };

  assign status_a_alt = {
    drive_in.irq,
    drive_in.dma_request_pending,
    step_latch,
    ~drive_in.track_zero_n,
    ~drive_in.head_side_select,
    ~drive_in.index_pulse_n,
    ~drive_in.write_protect_n,
    ~drive_in.direction
  };

  // Layout picked by mode
  wire logic [7:0] status_a;

  assign status_a = mode_alt ? status_a_alt
                  : mode_enh ? status_a_enh : 8'h00;

  // ----------------------------------------
  // Status B layout
  // ----------------------------------------

  // Same layout in both visible modes
  wire logic [7:0] status_b;

  assign status_b = {
    `FSRB_ONES2,
    doc[`FSRB_DOC_SEL0],
    wdata_tog,
    rdata_tog,
    drive_in.write_gate,
    doc[`FSRB_DOC_MOTOR1],
    doc[`FSRB_DOC_MOTOR0]
  };

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------

  // Bus is driven for this offset
  wire logic drive_a;
  wire logic drive_b;
  wire logic drive_hit;

  // Baseline leaves A and B undriven
  assign drive_a = sel_a & ~mode_base;
  assign drive_b = sel_b & ~mode_base;

  assign drive_hit = drive_a | drive_b | sel_doc | sel_tape
                   | sel_main | sel_fifo | sel_input;

  // Selected read value
  logic [7:0] rd_value;

  // Unmatched offsets return zero but are
  // also not driven, so the value is moot
  always_comb begin
    rd_value = 8'h00;
    if (drive_a) begin
      rd_value = status_a;
    end else if (drive_b) begin
      rd_value = status_b;
    end else if (sel_doc) begin
      rd_value = doc;
    end else if (sel_tape) begin
      rd_value = {`FSRB_ZEROS6, tape_sel};
    end else if (sel_main) begin
      rd_value = core_main_stat;
    end else if (sel_fifo) begin
      rd_value = core_fifo;
    end else if (sel_input) begin
      rd_value = core_input_stat;
    end
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------

  // Answer one cycle after the read strobe,
  // held for exactly one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata    <= 8'h00;
      io_rdata_oe <= 1'b0;
    end else begin
      io_rdata    <= (io_rd & drive_hit) ? rd_value : 8'h00;
      io_rdata_oe <= io_rd & drive_hit;
    end
  end

  // ----------------------------------------
  // Strobes towards the core
  // ----------------------------------------

  // Next strobe values
  fsrb_pkg::fsrb_strobe_type next_strobe;

  // Rate select and main status share 4,
  // config and input status share 7
  always_comb begin
    next_strobe.rate_wr   = io_wr & sel_main;
    next_strobe.fifo_wr   = io_wr & sel_fifo;
    next_strobe.fifo_rd   = io_rd & sel_fifo;
    next_strobe.config_wr = io_wr & sel_input;
    next_strobe.input_rd  = rd_input;
  end

  // Registered so strobes and data line up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_strobe <= '0;
      core_wdata  <= 8'h00;
    end else begin
      core_strobe <= next_strobe;
      core_wdata  <= io_wr ? io_wdata : 8'h00;
    end
  end

endmodule : fsrb_bank

/* File: tb/fsrb_drive_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Drive side: pins of one floppy drive
// ----------------------------------------
module fsrb_drive_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic motor_on,
  input  wire logic protected_in,
  input  wire logic track0_in,
  input  wire logic flux_kick,
  output logic      write_protect_n,
  output logic      index_pulse_n,
  output logic      track_zero_n,
  output logic      read_data
);
  logic [3:0] turn; // Spindle position, index every 16 cycles

  // Drive pins are active low
  assign write_protect_n = ~protected_in;
  assign track_zero_n    = ~track0_in;
  assign index_pulse_n   = ~(motor_on && (turn == 4'h0));

  // Spindle turns only with motor on; one flux pulse per kick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      turn      <= 4'h0;
      read_data <= 1'h0;
    end else begin
      turn      <= motor_on ? turn + 4'h1 : turn;
      read_data <= flux_kick;
    end
  end
endmodule : fsrb_drive_model

/* File: tb/fsrb_bank_sva.sv */
`timescale 1ns/10ps
module fsrb_bank_sva (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [2:0]                   io_addr,
  input wire logic                         io_rd,
  input wire logic [7:0]                   io_rdata,
  input wire logic                         io_rdata_oe,
  input wire fsrb_pkg::fsrb_mode_type      compat_mode,
  input wire fsrb_pkg::fsrb_drive_in_type  drive_in,
  input wire fsrb_pkg::fsrb_drive_out_type drive_out,
  input wire fsrb_pkg::fsrb_strobe_type    core_strobe
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  wire logic       enh  = compat_mode == fsrb_pkg::fsrb_mode_enhanced;
  wire logic       alt  = compat_mode == fsrb_pkg::fsrb_mode_alternate;
  wire logic       rd_a = io_rd && (io_addr == 3'h0);
  wire logic       rd_b = io_rd && (io_addr == 3'h1) && (enh || alt);
  // Live pin bits of the enhanced layout, low six
  wire logic [5:0] pins = {drive_in.step, drive_in.track_zero_n, drive_in.head_side_select,
                           drive_in.index_pulse_n, drive_in.write_protect_n, drive_in.direction};

  chk_rsvd_silent: assert property (io_rd && io_addr == 3'h6 |=> !io_rdata_oe)
    else $error("offset six answered");
  chk_input_strobe: assert property (io_rd && io_addr == 3'h7 |=> core_strobe.input_rd)
    else $error("input read strobe missing");
  chk_base_hidden: assert property (
    io_rd && io_addr[2:1] == 2'h0 && !enh && !alt |=> !io_rdata_oe)
    else $error("status driven in baseline");
  chk_enh_upper: assert property (
    rd_a && enh |=> io_rdata_oe && io_rdata[7:6] == {$past(drive_in.irq), 1'h1})
    else $error("enhanced status a upper bits wrong");
  chk_enh_pins: assert property (rd_a && enh |=> io_rdata[5:0] == $past(pins))
    else $error("enhanced status a pin bits wrong");
  chk_alt_inverted: assert property (
    rd_a && alt |=> io_rdata[4:0] == ~$past(pins[4:0]) && io_rdata[7] == $past(drive_in.irq)
    && io_rdata[6] == $past(drive_in.dma_request_pending))
    else $error("alternate status a bits wrong");
  chk_b_fixed: assert property (
    rd_b |=> io_rdata_oe && io_rdata[7:6] == 2'h3 && io_rdata[2] == $past(drive_in.write_gate))
    else $error("status b fixed or gate bits wrong");
  chk_b_drive: assert property (
    rd_b |=> io_rdata[5] == $past(drive_out.drive_sel[0])
    && io_rdata[1:0] == {$past(drive_out.motor_out_1), $past(drive_out.motor_out_0)})
    else $error("status b drive bits wrong");
  chk_idle_quiet: assert property (!io_rd |=> !io_rdata_oe)
    else $error("read data driven without read");
endmodule : fsrb_bank_sva

bind fsrb_bank fsrb_bank_sva fsrb_bank_sva_i (.clk(clk), .rst(rst), .io_addr(io_addr),
  .io_rd(io_rd), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .compat_mode(compat_mode),
  .drive_in(drive_in), .drive_out(drive_out), .core_strobe(core_strobe));

/* File: tb/tb_fsrb_bank.sv */
`timescale 1ns/10ps
module tb_fsrb_bank;
  logic                         clk, rst, io_rd, io_wr, oe, wd, prot, trk0, kick;
  logic                         wp_n, idx_n, trk0_n, rdat;
  logic [2:0]                   io_addr;
  logic [7:0]                   io_wdata, rdata, cwd;
  logic [5:0]                   cb; // Core bits: head_side_select, step, dir, write_gate, irq, dma
  int                           fail_count, num_checks, cyc;
  fsrb_pkg::fsrb_mode_type      mode;
  fsrb_pkg::fsrb_drive_out_type dout;
  fsrb_pkg::fsrb_drive_in_type  din;
  fsrb_pkg::fsrb_strobe_type    strb; // Core strobes, one-cycle pulses
  assign din = {wp_n, idx_n, trk0_n, cb[5:3], rdat, wd, cb[2:0]};
  // Rows: mode, addr, core bits, {protect, track0}, oe, data
  logic [21:0] rows [13] = '{
    {2'h0, 3'h0, 6'h00, 2'h0, 1'h1, 8'h56}, {2'h0, 3'h0, 6'h3a, 2'h3, 1'h1, 8'hed},
    {2'h1, 3'h0, 6'h2b, 2'h3, 1'h1, 8'hd2}, {2'h1, 3'h0, 6'h00, 2'h0, 1'h1, 8'h09},
    {2'h0, 3'h1, 6'h04, 2'h0, 1'h1, 8'hc4}, {2'h1, 3'h1, 6'h00, 2'h0, 1'h1, 8'hc0},
    {2'h2, 3'h0, 6'h00, 2'h0, 1'h0, 8'h00}, {2'h2, 3'h1, 6'h00, 2'h0, 1'h0, 8'h00},
    {2'h0, 3'h6, 6'h00, 2'h0, 1'h0, 8'h00}, {2'h1, 3'h4, 6'h00, 2'h0, 1'h1, 8'h5a},
    {2'h0, 3'h7, 6'h00, 2'h0, 1'h1, 8'ha5}, {2'h3, 3'h1, 6'h00, 2'h0, 1'h0, 8'h00},
    {2'h0, 3'h5, 6'h00, 2'h0, 1'h1, 8'h3c}};

  fsrb_bank fsrb_bank_i (.clk(clk), .rst(rst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(rdata), .io_rdata_oe(oe),
    .compat_mode(mode), .drive_in(din), .core_main_stat(8'h5a), .core_fifo(8'h3c),
    .core_input_stat(8'ha5), .drive_out(dout), .core_strobe(strb), .core_wdata(cwd));
  fsrb_drive_model fsrb_drive_model_i (.clk(clk), .rst(rst), .motor_on(dout.motor_out_0),
    .protected_in(prot), .track0_in(trk0), .flux_kick(kick), .write_protect_n(wp_n),
    .index_pulse_n(idx_n), .track_zero_n(trk0_n), .read_data(rdat));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One read cycle, answer seen in the following cycle
  task automatic rd(input logic [2:0] a, input logic eo, input logic [7:0] ed);
    io_addr = a;
    io_rd = 1'h1;
    @(negedge clk);
    io_rd = 1'h0;
    check({7'h00, oe}, {7'h00, eo});
    check(rdata, ed);
    check({3'h0, strb}, {5'h00, a == 3'h5, 1'h0, a == 3'h7});
    // Idle edge so a second call never re-raises the strobe in the same step
    @(negedge clk);
  endtask : rd
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'h1;
    @(negedge clk);
    io_wr = 1'h0;
    check(cwd, d);
    check({3'h0, strb}, {3'h0, a == 3'h4, a == 3'h5, 1'h0, a == 3'h7, 1'h0});
    if (a == 3'h2) check({2'h0, dout}, {2'h0, d[5:4], d[1:0], d[3], ~d[2]});
    // Idle edge between back-to-back writes
    @(negedge clk);
  endtask : wr
  task automatic results;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, io_rd, io_wr, io_addr, io_wdata, cb, wd, prot, trk0, kick} = 24'h800000;
    mode = fsrb_pkg::fsrb_mode_enhanced;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    foreach (rows[i]) begin
      mode = fsrb_pkg::fsrb_mode_type'(rows[i][21:20]);
      cb = rows[i][16:11];
      {prot, trk0} = rows[i][10:9];
      repeat (3) @(negedge clk); // Lets a step latch cleared by soft reset settle
      rd(rows[i][19:17], rows[i][8], rows[i][7:0]);
    end
    $display("table rows done");
    wr(3'h2, 8'h31);
    rd(3'h1, 1'h1, 8'he3);
    rd(3'h2, 1'h1, 8'h31);
    wr(3'h2, 8'h35);
    wr(3'h2, 8'h31);
    rd(3'h1, 1'h1, 8'he3);
    wr(3'h3, 8'hfe);
    rd(3'h3, 1'h1, 8'h02);
    wr(3'h4, 8'h02);
    wr(3'h5, 8'h3c);
    wr(3'h7, 8'h01);
    wr(3'h6, 8'hff);
    rd(3'h6, 1'h0, 8'h00);
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    rd(3'h1, 1'h1, 8'hc0);
    rd(3'h2, 1'h1, 8'h00);
    rd(3'h3, 1'h1, 8'h00);
    $display("motor and reset test done");
    kick = 1'h1;
    @(negedge clk);
    kick = 1'h0;
    wd = 1'h1;
    @(negedge clk);
    wd = 1'h0;
    repeat (2) @(negedge clk);
    rd(3'h1, 1'h1, 8'hd8);
    $display("toggle test done");
    mode = fsrb_pkg::fsrb_mode_alternate;
    wr(3'h2, 8'h04);
    cb = 6'h10;
    @(negedge clk);
    cb = 6'h00;
    repeat (2) @(negedge clk);
    rd(3'h0, 1'h1, 8'h29);
    rd(3'h0, 1'h1, 8'h29);
    rd(3'h7, 1'h1, 8'ha5);
    rd(3'h0, 1'h1, 8'h09);
    // Step edge and clearing read on one edge: the set must win
    cb = 6'h10;
    rd(3'h7, 1'h1, 8'ha5);
    cb = 6'h00;
    rd(3'h0, 1'h1, 8'h29);
    $display("step latch test done");
    results();
  end
endmodule : tb_fsrb_bank
